// >>> logic/sar_adc_serial_frame_control.v
// serial frame and conversion sequencing of an eight channel 12-bit sar converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"

module sar_adc_serial_frame_control #(
  parameter             RESULT_W = `RESULT_W,
  parameter             CHAN_W   = `CHAN_W
) (
  // clock and reset
  input  wire                i_clk,
  input  wire                i_nrst,
  // serial pins from the host
  input  wire                i_cs_n,
  input  wire                i_sclk,
  input  wire                i_din,
  // serial data pin to the host
  output wire                o_dout,
  output wire                o_dout_oe,
  // converter core control
  output wire                o_track,
  output wire                o_power_down,
  output wire                o_convert_start,
  output wire [CHAN_W-1:0]   o_conv_chan,
  output wire [CHAN_W-1:0]   o_chan_select,
  // result words from the converter core
  input  wire [RESULT_W-1:0] i_result,
  input  wire                i_result_valid,
  output wire                o_result_ready
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------

  wire       cs_n_s;
  wire       sclk_s;
  wire       din_s;

  // chip select idles high so it resets high, keeping the frame closed
  pin_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (i_cs_n),
    .o_sync  (cs_n_s)
  );

  // clock and data share one synchroniser so their skew stays equal
  pin_sync #(
    .W       (2),
    .RST_VAL (2'b00)
  ) u_sd_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({i_sclk, i_din}),
    .o_sync  ({sclk_s, din_s})
  );

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------

  reg        cs_n_q_reg;
  reg        sclk_q_reg;
  wire       cs_low;
  wire       cs_fall;
  wire       cs_rise;
  wire       sclk_fall;
  wire       sclk_rise;
  wire       fall_ev;
  wire       rise_ev;

  // delayed copies of the synchronised pins; an edge is a difference
  // between copy and pin, so each sclk phase must span at least one
  // system clock or that edge is lost
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      cs_n_q_reg <= 1'b1;
      sclk_q_reg <= 1'b0;
    end else begin
      cs_n_q_reg <= cs_n_s;
      sclk_q_reg <= sclk_s;
    end
  end

  assign cs_low    = ~cs_n_s;
  assign cs_fall   = cs_n_q_reg & ~cs_n_s;
  assign cs_rise   = ~cs_n_q_reg & cs_n_s;
  assign sclk_fall = sclk_q_reg & ~sclk_s;
  assign sclk_rise = ~sclk_q_reg & sclk_s;

  // clock edges only count inside a frame; a fall coinciding with the
  // chip select fall is consumed by the frame start itself
  assign fall_ev   = sclk_fall & cs_low & ~cs_fall;
  assign rise_ev   = sclk_rise & cs_low & ~cs_fall;

  // ---------------------------------------------------------------
  // phase decoding
  // ---------------------------------------------------------------

  // track covers the first three falls of each conversion; the sample
  // is frozen on fall four, when hold begins
  function in_track;
    input [`EDGE_CNT_W-1:0] cnt;
    begin
      in_track = (cnt >= `EDGE_FIRST) && (cnt <= `EDGE_TRACK_LAST);
    end
  endfunction

  // the core is idle outside a conversion and after its last fall
  function in_idle;
    input [`EDGE_CNT_W-1:0] cnt;
    begin
      in_idle = (cnt == `EDGE_NONE) || (cnt == `EDGE_CONV_LAST);
    end
  endfunction

  // ---------------------------------------------------------------
  // falling edge sequencer
  // ---------------------------------------------------------------

  reg  [`EDGE_CNT_W-1:0] fall_cnt_reg;
  reg  [`EDGE_CNT_W-1:0] fall_cnt_next;
  reg                    conv_begin;

  // fall counter, 0 = waiting for the first fall, 1..16 = fall number;
  // count 16 doubles as the idle point between back to back conversions,
  // which saves a separate idle state
  always @* begin
    fall_cnt_next = fall_cnt_reg;
    conv_begin    = 1'b0;
    if (!cs_low) begin
      fall_cnt_next = `EDGE_NONE;
    end else if (cs_fall) begin
      if (!sclk_s) begin
        // clock already low or falling with chip select
        fall_cnt_next = `EDGE_FIRST;
        conv_begin    = 1'b1;
      end else begin
        fall_cnt_next = `EDGE_NONE;
      end
    end else if (fall_ev) begin
      if (in_idle(fall_cnt_reg)) begin
        // first fall of a frame or of a back to back conversion
        fall_cnt_next = `EDGE_FIRST;
        conv_begin    = 1'b1;
      end else begin
        fall_cnt_next = fall_cnt_reg + 1'b1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_nrst)
      fall_cnt_reg <= `EDGE_NONE;
    else
      fall_cnt_reg <= fall_cnt_next;
  end

  // ---------------------------------------------------------------
  // rising edge counter and control word capture
  // ---------------------------------------------------------------

  reg  [`EDGE_CNT_W-1:0]  rise_cnt_reg;
  reg  [`CTRL_WORD_W-1:0] ctrl_shift_reg;
  reg  [`CTRL_WORD_W-1:0] channel_select_control_reg;
  wire [`CTRL_WORD_W-1:0] ctrl_shift_next;

  assign ctrl_shift_next = {ctrl_shift_reg[`CTRL_WORD_W-2:0], din_s};

  // the rise count restarts with each conversion; a partial control word
  // from an aborted conversion never reaches the control register
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      rise_cnt_reg               <= `EDGE_NONE;
      ctrl_shift_reg             <= `CTRL_RESET;
      channel_select_control_reg <= `CTRL_RESET;
    end else if (!cs_low || conv_begin) begin
      rise_cnt_reg   <= `EDGE_NONE;
      ctrl_shift_reg <= `CTRL_RESET;
    end else if (rise_ev && (fall_cnt_reg != `EDGE_NONE)) begin
      if (rise_cnt_reg != `EDGE_CONV_LAST)
        rise_cnt_reg <= rise_cnt_reg + 1'b1;
      if (rise_cnt_reg < `EDGE_CTRL_LAST) begin
        ctrl_shift_reg <= ctrl_shift_next;
        if (rise_cnt_reg == `EDGE_CTRL_LAST - 1'b1)
          channel_select_control_reg <= ctrl_shift_next;
      end
    end
  end

  // only the address field is ever read out of the control register
  assign o_chan_select =
    channel_select_control_reg[`CHAN_SEL_MSB:`CHAN_SEL_LSB];

  // ---------------------------------------------------------------
  // channel sequencing
  // ---------------------------------------------------------------

  reg [CHAN_W-1:0] conv_chan_reg;

  // the channel loaded in one conversion steers the next one; after reset
  // channel zero is used, which the host must not rely on
  always @(posedge i_clk) begin
    if (!i_nrst)
      conv_chan_reg <= `CHAN_RESET;
    else if (conv_begin)
      conv_chan_reg <= o_chan_select;
  end

  assign o_conv_chan = conv_chan_reg;

  // ---------------------------------------------------------------
  // core mode outputs
  // ---------------------------------------------------------------

  reg track_reg;
  reg power_down_reg;
  reg convert_start_reg;

  // registered from the next count so they line up with the edge itself;
  // registering costs no extra stage of latency and buys glitch free control of the core
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      track_reg         <= 1'b0;
      power_down_reg    <= 1'b1;
      convert_start_reg <= 1'b0;
    end else begin
      track_reg         <= in_track(fall_cnt_next);
      power_down_reg    <= in_idle(fall_cnt_next);
      convert_start_reg <= fall_ev &&
                           (fall_cnt_next == `EDGE_HOLD_START);
    end
  end

  assign o_track         = track_reg;
  assign o_power_down    = power_down_reg;
  assign o_convert_start = convert_start_reg;

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------

  wire [RESULT_W-1:0] buf_data;
  wire                buf_valid;
  wire                buf_pop;

  // the shifter drains one word per conversion, so a core that runs
  // ahead fills the buffer and then sees its ready drop
  word_fifo2 #(
    .W       (RESULT_W),
    .DEPTH   (2),
    .PTR_W   (1)
  ) u_result_buf (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_flush (cs_rise),
    .i_data  (i_result),
    .i_valid (i_result_valid),
    .o_ready (o_result_ready),
    .o_data  (buf_data),
    .o_valid (buf_valid),
    .i_ready (buf_pop)
  );

  // the word leaves the buffer on the fall that shows its msb
  assign buf_pop = fall_ev && (fall_cnt_next == `EDGE_DATA_START);

  // ---------------------------------------------------------------
  // serial output shifter
  // ---------------------------------------------------------------

  reg [RESULT_W-1:0] res_shift_reg;
  reg                dout_reg;
  reg                dout_oe_reg;
  wire [RESULT_W-1:0] load_word;

  // an empty buffer at the first data fall shifts out zeros instead
  assign load_word = buf_valid ? buf_data : `RESULT_ZERO;

  // each counted fall presents the next bit; the word is sent as is,
  // so any coding the core applies reaches the host unchanged
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      res_shift_reg <= `RESULT_ZERO;
      dout_reg      <= 1'b0;
    end else if (!cs_low) begin
      res_shift_reg <= `RESULT_ZERO;
      dout_reg      <= 1'b0;
    end else if (conv_begin || fall_ev) begin
      if (fall_cnt_next < `EDGE_DATA_START) begin
        dout_reg <= 1'b0;
      end else if (fall_cnt_next == `EDGE_DATA_START) begin
        dout_reg      <= load_word[`RESULT_MSB];
        res_shift_reg <= {load_word[RESULT_W-2:0], 1'b0};
      end else begin
        dout_reg      <= res_shift_reg[`RESULT_MSB];
        res_shift_reg <= {res_shift_reg[RESULT_W-2:0], 1'b0};
      end
    end
  end

  // the enable follows chip select alone, with no clock edge needed;
  // it lags the pin by the synchroniser depth plus this stage
  always @(posedge i_clk) begin
    if (!i_nrst)
      dout_oe_reg <= 1'b0;
    else
      dout_oe_reg <= cs_low;
  end

  assign o_dout    = dout_reg;
  assign o_dout_oe = dout_oe_reg;

endmodule // sar_adc_serial_frame_control

`default_nettype wire

// >>> logic/sar_adc_regs.vh
// constants shared by the serial frame control block of the sar converter
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// ---------------------------------------------------------------
// control word layout (serial-loaded, write only)
// ---------------------------------------------------------------
`define CTRL_WORD_W       8
`define CTRL_RESET        8'h00
`define CHAN_SEL_MSB      5
`define CHAN_SEL_LSB      3
`define CHAN_W            3
`define CHAN_RESET        3'h0

// ---------------------------------------------------------------
// conversion framing, counted in serial clock edges
// ---------------------------------------------------------------
`define EDGE_CNT_W        5
`define EDGE_NONE         5'h00
`define EDGE_FIRST        5'h01
`define EDGE_TRACK_LAST   5'h03
`define EDGE_HOLD_START   5'h04
`define EDGE_DATA_START   5'h05
`define EDGE_CTRL_LAST    5'h08
`define EDGE_CONV_LAST    5'h10

// ---------------------------------------------------------------
// result word
// ---------------------------------------------------------------
`define RESULT_W          12
`define RESULT_ZERO       12'h000
`define RESULT_MSB        11

`endif

// >>> logic/pin_sync.v
// two flip-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter             W       = 1,
  parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input  wire           i_clk,
  input  wire           i_nrst,
  // asynchronous pins and their synchronised copy
  input  wire [W-1:0]   i_async,
  output wire [W-1:0]   o_sync
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // pin_sync

`default_nettype wire

// >>> logic/word_fifo2.v
// small valid/ready buffer holding result words between core and shifter
`timescale 1ns/1ps
`default_nettype none

module word_fifo2 #(
  parameter             W     = 12,
  parameter             DEPTH = 2,
  parameter             PTR_W = 1
) (
  // clock and reset
  input  wire           i_clk,
  input  wire           i_nrst,
  input  wire           i_flush,
  // fill side
  input  wire [W-1:0]   i_data,
  input  wire           i_valid,
  output wire           o_ready,
  // drain side
  output wire [W-1:0]   o_data,
  output wire           o_valid,
  input  wire           i_ready
);

  reg [W-1:0]   mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0] count_reg;
  wire          push;
  wire          pop;

  // honest flags straight from the fill count
  assign o_ready = (count_reg != DEPTH[PTR_W:0]);
  assign o_valid = (count_reg != {(PTR_W+1){1'b0}});
  assign o_data  = mem[rd_ptr_reg];
  assign push    = i_valid & o_ready;
  assign pop     = i_ready & o_valid;

  // pointer wrap helper, depth need not be a power of two
  function [PTR_W-1:0] ptr_inc;
    input [PTR_W-1:0] p;
    begin
      if (p == DEPTH[PTR_W-1:0] - 1'b1)
        ptr_inc = {PTR_W{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  // storage has no reset, only pointers and count do
  always @(posedge i_clk) begin
    if (push)
      mem[wr_ptr_reg] <= i_data;
  end

  // flush drops anything held, a push in the same cycle is dropped too
  always @(posedge i_clk) begin
    if (!i_nrst || i_flush) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg  <= {(PTR_W+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // word_fifo2

`default_nettype wire

// >>> testbench/sar_adc_frame_checker_assertions.sv
// concurrent checks on the port behaviour of the serial frame control block
`timescale 1ns/1ps
`default_nettype none

module sar_adc_frame_checker #(
  parameter CHAN_W = 3
) (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_nrst,
  // serial pins
  input wire logic              i_cs_n,
  input wire logic              o_dout,
  input wire logic              o_dout_oe,
  // converter core control
  input wire logic              o_track,
  input wire logic              o_power_down,
  input wire logic              o_convert_start,
  input wire logic [CHAN_W-1:0] o_conv_chan,
  input wire logic [CHAN_W-1:0] o_chan_select
);
  // ------------
  // frame checks
  // ------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // bounds allow for the pin synchroniser, whose phase to the pin is unknown
  property p_oe_on;
    $fell(i_cs_n) |-> ##[2:5] o_dout_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("dout not enabled");

  property p_oe_off;
    $rose(i_cs_n) |-> ##[2:5] (!o_dout_oe && o_power_down && !o_track);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("frame end ignored");

  property p_quiet;
    !o_dout_oe |-> !o_dout;
  endproperty
  a_quiet: assert property (p_quiet) else $error("dout high while off");

  property p_hold;
    $fell(o_track) && !o_power_down |-> o_convert_start;
  endproperty
  a_hold: assert property (p_hold) else $error("track ended without hold");

  property p_start;
    o_convert_start |-> $past(o_track) && !o_track ##1 !o_convert_start;
  endproperty
  a_start: assert property (p_start) else $error("bad hold start");

  property p_chan;
    $rose(o_track) |-> o_conv_chan == $past(o_chan_select);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel loaded");

  property p_awake;
    o_track |-> !o_power_down && o_dout_oe && !o_dout;
  endproperty
  a_awake: assert property (p_awake) else $error("bad state in track");

  property p_wake;
    $fell(o_power_down) |-> o_track;
  endproperty
  a_wake: assert property (p_wake) else $error("woke outside fall one");

  // an abort may end the hold early, but only together with the enable
  property p_busy;
    o_convert_start |-> (!o_power_down || !o_dout_oe) [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("core asleep in hold");

  // a stray clock while deselected must leave track, power down and the channel select alone
  property p_idle;
    i_cs_n && $past(i_cs_n, 6) |-> !o_track && o_power_down && $stable(o_chan_select);
  endproperty
  a_idle: assert property (p_idle) else $error("activity while deselected");

endmodule // sar_adc_frame_checker

bind sar_adc_serial_frame_control sar_adc_frame_checker #(.CHAN_W(CHAN_W)) i_frame_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .o_dout(o_dout),
  .o_dout_oe(o_dout_oe), .o_track(o_track), .o_power_down(o_power_down),
  .o_convert_start(o_convert_start), .o_conv_chan(o_conv_chan),
  .o_chan_select(o_chan_select)
);

`default_nettype wire

// >>> testbench/serial_host_model.sv
// behavioural serial host that frames conversions and reads the result
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  // serial pins toward the device
  output var logic  o_cs_n,
  output var logic  o_sclk,
  output var logic  o_din,
  // data pin from the device
  input wire logic  i_dout,
  input wire logic  i_dout_oe
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end

  // mode 0 clock low, 1 clock high then falls, 2 both fall together
  task automatic open_frame(input int mode);
    #0.3;
    o_sclk = (mode != 0);
    #101;
    o_cs_n = 1'b0;
    if (mode == 2) o_sclk = 1'b0;
    if (mode == 1) begin
      #62.5;
      o_sclk = 1'b0;
    end
  endtask

  // n clock cycles; the last one stays high unless another conversion follows
  task automatic conv(input logic [7:0] ctrl, input int n, input bit last,
                      output logic [15:0] got);
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      o_din = (i < 8) ? ctrl[7-i] : ~o_din;
      #62.5;
      o_sclk = 1'b1;
      got[15-i] = i_dout & i_dout_oe;  // an undriven line reads as low
      #62.5;
      if (!(last && i == n - 1)) o_sclk = 1'b0;
    end
  endtask

  // deselect, then a clock fall that the device must ignore
  task automatic close_frame();
    #21;
    o_cs_n = 1'b1;
    #63;
    o_sclk = 1'b0;
    o_din = ~o_din;
  endtask
endmodule // serial_host_model

`default_nettype wire

// >>> testbench/sar_adc_serial_frame_control_tb.sv
// self-checking bench for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.vh"

module sar_adc_serial_frame_control_tb;
  logic                 clk, nrst, cs_n, sclk, din, dout, dout_oe;
  logic                 track, pwr_dn, cstart, rvalid, rready, auto_core;
  logic [`CHAN_W-1:0]   conv_chan, chan_sel, prev;
  logic [`RESULT_W-1:0] rdata;
  logic [11:0]          exp_q[$];
  int                   fails, cmp_count;
  real                  t_trk;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  sar_adc_serial_frame_control i_dut (
    .i_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .o_dout(dout), .o_dout_oe(dout_oe), .o_track(track), .o_power_down(pwr_dn),
    .o_convert_start(cstart), .o_conv_chan(conv_chan), .o_chan_select(chan_sel),
    .i_result(rdata), .i_result_valid(rvalid), .o_result_ready(rready)
  );

  serial_host_model i_host (
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout), .i_dout_oe(dout_oe)
  );

  // ----------------
  // checking helpers
  // ----------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // four leading zeros, then the result msb first
  function automatic logic [15:0] exp_word(input logic [11:0] w);
    return {4'h0, w};
  endfunction

  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // core side: hold the word until the buffer takes it
  task automatic push(input logic [11:0] w);
    exp_q.push_back(w);
    rdata = w;
    rvalid = 1'b1;
    @(posedge clk);
    while (rready !== 1'b1) @(posedge clk);
    #1 rvalid = 1'b0;
  endtask

  // while auto_core is set, the core answers each hold start with a fresh random word
  always @(posedge clk) if (auto_core && cstart) begin
    #1 push(12'($urandom));
  end

  // track spans three clock periods of 125 ns
  always @(posedge track) begin
    t_trk = $realtime;
    #1 check(16'(conv_chan), 16'(prev));
  end
  always @(negedge track) if (nrst)
    check(16'(($realtime - t_trk) > 355.0 && ($realtime - t_trk) < 395.0), 16'h1);

  // one frame of nconv conversions; a short first one is aborted
  task automatic frame(input int mode, input int nconv, input int n0);
    logic [7:0]  ctrl;
    logic [15:0] got;
    logic [11:0] w;
    int          n;
    i_host.open_frame(mode);
    for (int c = 0; c < nconv; c++) begin
      ctrl = 8'($urandom);
      n = (c == 0) ? n0 : 16;
      i_host.conv(ctrl, n, c == nconv - 1 || n != 16, got);
      w = exp_q.pop_front();
      if (n == 16) begin
        check(got, exp_word(w));
        check(16'({pwr_dn, track}), 16'h0002);
        prev = ctrl[5:3];
      end
      check(16'(chan_sel), 16'(prev));
      if (n != 16) break;
    end
    i_host.close_frame();
    #(1 + $urandom % 3000);
  endtask

  // ---------------
  // main sequence
  // ---------------
  initial begin
    nrst = 1'b0;
    rvalid = 1'b0;
    rdata = `RESULT_ZERO;
    auto_core = 1'b1;
    prev = `CHAN_RESET;
    void'($urandom(32'hc5be));
    repeat (3) @(posedge clk);
    #1;
    check(16'({dout_oe, dout, track, cstart, pwr_dn, rready}), 16'h0003);
    check(16'({conv_chan, chan_sel}), 16'h0000);
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    // the first frame is the dummy conversion that loads a channel
    for (int f = 0; f < 12; f++)
      frame(f % 3, 1 + $urandom % 3, (f == 4) ? 6 : 16);
    // fill the buffer with the codes fff and 001 until it refuses
    auto_core = 1'b0;
    @(posedge clk) #1 push(12'hfff);
    @(posedge clk) #1 push(12'h001);
    @(posedge clk) #1 check(16'(rready), 16'h0000);
    exp_q.push_back(`RESULT_ZERO);
    frame(1, 3, 16);
    auto_core = 1'b1;
    frame(0, 2, 16);
    end_sim();
  end

  // hang guard, well beyond the expected run time
  initial begin
    #600000;
    fails++;
    end_sim();
  end
endmodule // sar_adc_serial_frame_control_tb

`default_nettype wire
